// [verilog/lpm_pkg.sv]
// constants of the light and proximity measurement controller
// How it works
// (RULE_01) config bit 5 enables, bit 4 selects hysteresis
// (RULE_02) side bit low lower, high upper threshold
// (RULE_03) integration code picks 6.25 to 800 ms
// (RULE_04) host avoids integration below 50 ms
// (RULE_05) light repeat wait is field times 50 ms
// (RULE_06) light wait zero means continuous measuring
// (RULE_07) light wait resets to 500 ms
// (RULE_08) light sensor powers off after each measurement
// (RULE_09) light result frozen from read start to stop
// (RULE_10) reset loads defaults and enters standby
// (RULE_11) writing 0x01 to 0x01 resets whole device
// (RULE_12) host writes configuration at 0x02 to 0x27
// (RULE_13) register address advances on each written byte
// (RULE_14) stop after control write starts proximity cycle
// (RULE_15) oscillator, calibrate, then LED on/off samples
// (RULE_16) proximity result is lit minus ambient sample
// (RULE_17) one-shot powers down, oscillator kept for light
// (RULE_18) repeat mode waits interval then repeats forever
// (RULE_19) proximity wait is register times 5 ms
// (RULE_20) default proximity cycle finishes under 2 ms
// (RULE_21) bus target answers at address 0x37
// (RULE_22) host reads after writing register address first
// (RULE_23) 16-bit values: high byte at lower address
// (RULE_24) config bits 7:6 ignored, bit 3 zero
package lpm_pkg;
	localparam logic [6:0] TARGET_ADDR      = 7'h37;
	localparam logic [7:0] PART_ID_VALUE    = 8'h5a; // arbitrary value
	// register offsets
	localparam logic [7:0] A_PART_ID        = 8'h00;
	localparam logic [7:0] A_SOFT_RESET     = 8'h01;
	localparam logic [7:0] A_CFG_FIRST      = 8'h02;
	localparam logic [7:0] A_PROX_UP_HIGH   = 8'h10;
	localparam logic [7:0] A_PROX_UP_LOW    = 8'h11;
	localparam logic [7:0] A_PROX_WAIT      = 8'h16;
	localparam logic [7:0] A_PROX_CTRL      = 8'h17;
	localparam logic [7:0] A_LIGHT_LO_HIGH  = 8'h22;
	localparam logic [7:0] A_LIGHT_LO_LOW   = 8'h23;
	localparam logic [7:0] A_LIGHT_CFG      = 8'h25;
	localparam logic [7:0] A_LIGHT_WAIT     = 8'h26;
	localparam logic [7:0] A_LIGHT_CTRL     = 8'h27;
	localparam logic [7:0] A_PROX_RES_HIGH  = 8'h41;
	localparam logic [7:0] A_PROX_RES_LOW   = 8'h42;
	localparam logic [7:0] A_LIGHT_RES_HIGH = 8'h43;
	localparam logic [7:0] A_LIGHT_RES_LOW  = 8'h44;
	// field positions and masks
	localparam int         HYST_EN_BIT      = 5;
	localparam int         HYST_SIDE_BIT    = 4;
	localparam logic [7:0] LIGHT_CFG_MASK   = 8'h37;
	localparam int         CTRL_ONESHOT_BIT = 0;
	localparam int         CTRL_REPEAT_BIT  = 1;
	localparam int         SOFT_RESET_BIT   = 0;
	// values after reset
	localparam logic [7:0] RST_LIGHT_CFG    = 8'h04;
	localparam logic [7:0] RST_LIGHT_WAIT   = 8'h0a;
	localparam logic [7:0] RST_PROX_WAIT    = 8'h0a;
	// timing: all sequencing runs on a 50 us tick
	localparam int         CLK_PERIOD_NS    = 10;
	localparam int         TICK_US          = 50;
	localparam int         TICK_CYCLES      = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int         LIGHT_STEP_MS    = 50;
	localparam int         LIGHT_STEP_TICKS = LIGHT_STEP_MS * 1000 / TICK_US;
	localparam int         PROX_STEP_MS     = 5;
	localparam int         PROX_STEP_TICKS  = PROX_STEP_MS * 1000 / TICK_US;
	localparam int         INTEG_BASE_US    = 6250;
	localparam int         INTEG_BASE_TICKS = INTEG_BASE_US / TICK_US;
	localparam int         OSC_START_US     = 200;
	localparam int         OSC_START_TICKS  = (OSC_START_US + TICK_US - 1) / TICK_US;
	localparam int         RX_CAL_US        = 200;
	localparam int         RX_CAL_TICKS     = (RX_CAL_US + TICK_US - 1) / TICK_US;
	localparam int         RX_INTEG_US      = 300;
	localparam int         RX_INTEG_TICKS   = (RX_INTEG_US + TICK_US - 1) / TICK_US;
endpackage

// [verilog/lpm_i2c_target.sv]
// two-wire bus target: bit engine, address match, byte events
`timescale 1ns/1ps
module lpm_i2c_target (
	input  wire logic       clk,        // system clock
	input  wire logic       rstn,       // async reset, active low
	input  wire logic       scl_in,     // bus clock from host
	input  wire logic       sda_in,     // bus data level
	output logic            sda_oe,     // high while pulling data low
	input  wire logic [7:0] rd_data,    // byte to send on reads
	output logic            wr_p,       // data byte received
	output logic            wr_first,   // byte is the register address
	output logic [7:0]      wr_data,    // received byte
	output logic            rd_begin_p, // read transaction addressed
	output logic            rd_ack_p,   // host acked a sent byte
	output logic            stop_p      // stop condition seen
);
	typedef enum logic [6:0] {
		T_IDLE = 7'b0000001,
		T_ADDR = 7'b0000010,
		T_AACK = 7'b0000100,
		T_WR   = 7'b0001000,
		T_WACK = 7'b0010000,
		T_RD   = 7'b0100000,
		T_MACK = 7'b1000000
	} lpm_tgt_state_t;

	lpm_tgt_state_t st;          // bus engine state
	logic       scl_m, scl_s, scl_d; // clock sync chain and history
	logic       sda_m, sda_s, sda_d; // data sync chain and history
	logic [3:0] cnt;             // bits moved in current byte
	logic [7:0] sh;              // receive shifter
	logic [7:0] tx;              // transmit shifter
	logic       rw;              // direction bit of address byte
	logic       first;           // next write byte is the pointer

	// two-flop synchronisers, the first flop feeds only the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
		end
	end

	wire rise  = scl_s & ~scl_d;
	wire fall  = ~scl_s & scl_d;
	wire start = scl_s & scl_d & sda_d & ~sda_s;
	wire stop  = scl_s & scl_d & ~sda_d & sda_s;

	// byte engine; outputs change on the detected clock fall, except rd_ack_p on the rise and stop_p
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= T_IDLE;
			cnt <= 4'h0;
			sh <= 8'h00;
			tx <= 8'h00;
			rw <= 1'b0;
			first <= 1'b0;
			sda_oe <= 1'b0;
			wr_p <= 1'b0;
			wr_first <= 1'b0;
			wr_data <= 8'h00;
			rd_begin_p <= 1'b0;
			rd_ack_p <= 1'b0;
			stop_p <= 1'b0;
		end else begin
			wr_p <= 1'b0;
			rd_begin_p <= 1'b0;
			rd_ack_p <= 1'b0;
			stop_p <= stop;
			if (start) begin
				st <= T_ADDR;
				cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop) begin
				st <= T_IDLE;
				sda_oe <= 1'b0;
			end else if (rise) begin
				if (st == T_ADDR || st == T_WR) begin
					sh <= {sh[6:0], sda_s};
					cnt <= cnt + 4'h1;
				end else if (st == T_MACK) begin
					// a released line is a nack: go idle until the next start
					if (sda_s)
						st <= T_IDLE;
					else
						rd_ack_p <= 1'b1;
				end
			end else if (fall) begin
				unique case (st)
					T_IDLE: ;
					T_ADDR: if (cnt == 4'h8) begin
						// (RULE_21) own address match
						if (sh[7:1] == lpm_pkg::TARGET_ADDR) begin
							sda_oe <= 1'b1;
							rw <= sh[0];
							rd_begin_p <= sh[0];
							st <= T_AACK;
						end else begin
							st <= T_IDLE;
						end
					end
					T_AACK, T_MACK: begin
						cnt <= 4'h1;
						if (st == T_AACK && !rw) begin
							sda_oe <= 1'b0;
							first <= 1'b1;
							cnt <= 4'h0;
							st <= T_WR;
						end else begin
							tx <= rd_data;
							sda_oe <= ~rd_data[7];
							st <= T_RD;
						end
					end
					T_WR: if (cnt == 4'h8) begin
						sda_oe <= 1'b1;
						wr_p <= 1'b1;
						wr_first <= first;
						wr_data <= sh;
						st <= T_WACK;
					end
					T_WACK: begin
						sda_oe <= 1'b0;
						first <= 1'b0;
						cnt <= 4'h0;
						st <= T_WR;
					end
					T_RD: if (cnt == 4'h8) begin
						sda_oe <= 1'b0;
						st <= T_MACK;
					end else begin
						sda_oe <= ~tx[6];
						tx <= {tx[6:0], 1'b0};
						cnt <= cnt + 4'h1;
					end
				endcase
			end
		end
	end
endmodule

// [verilog/lpm_measure_ctrl.sv]
// light and proximity measurement sequencer with its register file
`timescale 1ns/1ps
module lpm_measure_ctrl #(
	parameter int TICK_CYCLES = lpm_pkg::TICK_CYCLES // cycles per 50 us tick
) (
	input  wire logic        clk,              // 100 MHz system clock
	input  wire logic        rstn,             // async reset, active low
	input  wire logic        scl_in,           // bus clock pin
	input  wire logic        sda_in,           // bus data pin level
	output logic             sda_out,          // bus data drive level
	output logic             sda_oe,           // bus data drive enable
	output logic             osc_en,           // precision oscillator run
	output logic             prox_rx_power,    // proximity receiver power
	output logic             prox_rx_cal,      // receiver calibration
	output logic             led_on,           // infrared LED pulse
	output logic [7:0]       led_setting,      // LED current/frequency byte
	input  wire logic [15:0] prox_sample,      // receiver converter value
	output logic             light_power,      // light sensor circuitry on
	input  wire logic [15:0] light_sample,     // light converter value
	output logic             light_hyst_lower, // hysteresis on lower limit
	output logic             light_hyst_upper, // hysteresis on upper limit
	output logic [15:0]      prox_upper_threshold,  // upper proximity limit
	output logic [15:0]      light_lower_threshold, // lower light limit
	output logic [15:0]      prox_result       // last proximity result
);
	localparam int TW = $clog2(TICK_CYCLES);
	localparam logic [7:0] A_LED_SETTING = 8'h0f;

	// the divider needs at least two cycles per tick
	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("TICK_CYCLES must be 2 or more");
	end

	typedef enum logic [6:0] {
		P_IDLE    = 7'b0000001,
		P_OSC     = 7'b0000010,
		P_CAL     = 7'b0000100,
		P_LED_ON  = 7'b0001000,
		P_LED_OFF = 7'b0010000,
		P_CALC    = 7'b0100000,
		P_WAIT    = 7'b1000000
	} lpm_prox_state_t;

	typedef enum logic [2:0] {
		L_IDLE  = 3'b001,
		L_INTEG = 3'b010,
		L_WAIT  = 3'b100
	} lpm_light_state_t;

	logic [7:0]  cfg [0:63];      // configuration bytes by address
	logic [7:0]  ptr;             // register pointer
	logic [7:0]  rd_byte;         // byte offered to the bus
	logic        wr_p;            // byte written by host
	logic        wr_first;        // that byte was the pointer
	logic [7:0]  wr_data;         // written byte
	logic        rd_begin_p;      // read transaction started
	logic        rd_ack_p;        // host acked a read byte
	logic        stop_p;          // stop condition
	logic        srst;            // soft reset pulse
	logic        reset_pend;      // soft reset armed until stop
	logic        prox_pend;       // proximity control written
	logic        light_pend;      // light control written
	logic        prox_kick;       // start proximity sequencing
	logic        light_kick;      // start light sequencing
	logic [TW-1:0] div;           // tick divider
	logic        tick;            // one-cycle 50 us enable
	lpm_prox_state_t  pst;        // proximity sequencer
	lpm_light_state_t lst;        // light sequencer
	logic [15:0] p_cnt;           // ticks spent in proximity phase
	logic [15:0] l_cnt;           // ticks spent in light phase
	logic [15:0] p_len;           // length of current proximity phase
	logic [15:0] l_len;           // length of current light phase
	logic        p_end;           // proximity phase ends this cycle
	logic        l_end;           // light phase ends this cycle
	logic [15:0] lit;             // sample with LED on
	logic [15:0] amb;             // sample with LED off
	logic [15:0] light_live;      // newest light result
	logic [15:0] light_shadow;    // light result seen by the bus
	logic        lock;            // bus read in progress

	// (RULE_07) reset values, light wait 500 ms by default
	function automatic logic [7:0] reset_val(input logic [7:0] a);
		unique case (a)
			lpm_pkg::A_LIGHT_CFG:  reset_val = lpm_pkg::RST_LIGHT_CFG;
			lpm_pkg::A_LIGHT_WAIT: reset_val = lpm_pkg::RST_LIGHT_WAIT;
			lpm_pkg::A_PROX_WAIT:  reset_val = lpm_pkg::RST_PROX_WAIT;
			default:               reset_val = 8'h00;
		endcase
	endfunction

	// true for addresses that hold writable configuration
	function automatic logic writable(input logic [7:0] a);
		writable = (a >= lpm_pkg::A_CFG_FIRST) && (a <= lpm_pkg::A_LIGHT_CTRL);
	endfunction

	// two-wire target handles all pin timing
	lpm_i2c_target u_target (
		.clk        (clk),
		.rstn       (rstn),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.sda_oe     (sda_oe),
		.rd_data    (rd_byte),
		.wr_p       (wr_p),
		.wr_first   (wr_first),
		.wr_data    (wr_data),
		.rd_begin_p (rd_begin_p),
		.rd_ack_p   (rd_ack_p),
		.stop_p     (stop_p)
	);

	// open-drain: only ever drive low
	assign sda_out = 1'b0;

	// configuration store
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// (RULE_10) defaults at power-up
			for (int i = 0; i < 64; i++)
				cfg[i] <= reset_val(8'(i));
		end else if (srst) begin
			// (RULE_11) soft reset as power-up
			for (int i = 0; i < 64; i++)
				cfg[i] <= reset_val(8'(i));
		end else if (wr_p && !wr_first && writable(ptr)) begin
			// (RULE_24) drop don't-care and reserved bits
			if (ptr == lpm_pkg::A_LIGHT_CFG)
				cfg[ptr[5:0]] <= wr_data & lpm_pkg::LIGHT_CFG_MASK;
			else
				cfg[ptr[5:0]] <= wr_data;
		end
	end

	// register pointer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ptr <= 8'h00;
		end else if (srst) begin
			ptr <= 8'h00;
		end else if (wr_p) begin
			// (RULE_13) first byte loads, later bytes advance
			ptr <= wr_first ? wr_data : ptr + 8'h01;
		end else if (rd_ack_p) begin
			ptr <= ptr + 8'h01;
		end
	end

	// read data, registered so the target sees a steady byte
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_byte <= 8'h00;
		end else begin
			// (RULE_23) high byte at lower address
			unique case (ptr)
				lpm_pkg::A_PART_ID:        rd_byte <= lpm_pkg::PART_ID_VALUE;
				lpm_pkg::A_PROX_RES_HIGH:  rd_byte <= prox_result[15:8];
				lpm_pkg::A_PROX_RES_LOW:   rd_byte <= prox_result[7:0];
				lpm_pkg::A_LIGHT_RES_HIGH: rd_byte <= light_shadow[15:8];
				lpm_pkg::A_LIGHT_RES_LOW:  rd_byte <= light_shadow[7:0];
				default: rd_byte <= writable(ptr) ? cfg[ptr[5:0]] : 8'h00;
			endcase
		end
	end

	// writes armed during a transaction act at its stop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reset_pend <= 1'b0;
			prox_pend <= 1'b0;
			light_pend <= 1'b0;
			srst <= 1'b0;
			prox_kick <= 1'b0;
			light_kick <= 1'b0;
		end else begin
			srst <= stop_p & reset_pend;
			// (RULE_14) stop wakes the proximity sequencer
			prox_kick <= stop_p & prox_pend & ~reset_pend;
			light_kick <= stop_p & light_pend & ~reset_pend;
			if (stop_p || srst) begin
				reset_pend <= 1'b0;
				prox_pend <= 1'b0;
				light_pend <= 1'b0;
			end else if (wr_p && !wr_first) begin
				// (RULE_11) reset command armed
				if (ptr == lpm_pkg::A_SOFT_RESET && wr_data[lpm_pkg::SOFT_RESET_BIT])
					reset_pend <= 1'b1;
				if (ptr == lpm_pkg::A_PROX_CTRL)
					prox_pend <= 1'b1;
				if (ptr == lpm_pkg::A_LIGHT_CTRL)
					light_pend <= 1'b1;
			end
		end
	end

	// 50 us tick; a slower rate as an enable, not a clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (div == TW'(TICK_CYCLES - 1));
			div <= (div == TW'(TICK_CYCLES - 1)) ? '0 : div + 1'b1;
		end
	end

	// phase lengths in ticks
	always_comb begin
		unique case (pst)
			// (RULE_15) oscillator start, calibration, LED on and off
			// (RULE_20) phases total about 1 ms
			P_OSC:     p_len = 16'(lpm_pkg::OSC_START_TICKS);
			P_CAL:     p_len = 16'(lpm_pkg::RX_CAL_TICKS);
			P_LED_ON:  p_len = 16'(lpm_pkg::RX_INTEG_TICKS);
			P_LED_OFF: p_len = 16'(lpm_pkg::RX_INTEG_TICKS);
			// (RULE_19) wait in 5 ms steps
			P_WAIT: p_len = 16'(cfg[lpm_pkg::A_PROX_WAIT[5:0]] * lpm_pkg::PROX_STEP_TICKS);
			default:   p_len = 16'h0001;
		endcase
		unique case (lst)
			// (RULE_03) 6.25 ms doubled per code step
			L_INTEG: l_len = 16'(lpm_pkg::INTEG_BASE_TICKS) << cfg[lpm_pkg::A_LIGHT_CFG[5:0]][2:0];
			// (RULE_05) wait in 50 ms steps, six-bit field
			L_WAIT:  l_len = 16'(cfg[lpm_pkg::A_LIGHT_WAIT[5:0]][5:0] * lpm_pkg::LIGHT_STEP_TICKS);
			default: l_len = 16'h0001;
		endcase
		p_end = tick && (p_cnt == p_len - 16'h0001);
		l_end = tick && (l_cnt == l_len - 16'h0001);
	end

	wire [7:0] prox_ctrl  = cfg[lpm_pkg::A_PROX_CTRL[5:0]];
	wire [7:0] light_ctrl = cfg[lpm_pkg::A_LIGHT_CTRL[5:0]];
	wire prox_rep   = prox_ctrl[lpm_pkg::CTRL_REPEAT_BIT];
	wire prox_any   = prox_rep | prox_ctrl[lpm_pkg::CTRL_ONESHOT_BIT];
	wire light_rep  = light_ctrl[lpm_pkg::CTRL_REPEAT_BIT];
	wire light_any  = light_rep | light_ctrl[lpm_pkg::CTRL_ONESHOT_BIT];
	wire prox_wait0 = (cfg[lpm_pkg::A_PROX_WAIT[5:0]] == 8'h00);
	wire light_wait0 = (cfg[lpm_pkg::A_LIGHT_WAIT[5:0]][5:0] == 6'h00);

	// proximity sequencer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pst <= P_IDLE;
			p_cnt <= 16'h0000;
		end else if (srst) begin
			pst <= P_IDLE;
			p_cnt <= 16'h0000;
		end else if (prox_kick) begin
			// a control write restarts the cycle or stops it
			pst <= prox_any ? P_OSC : P_IDLE;
			p_cnt <= 16'h0000;
		end else begin
			unique case (pst)
				P_IDLE: ;
				P_CALC: begin
					p_cnt <= 16'h0000;
					// (RULE_17) one-shot ends in standby
					// (RULE_18) repeat mode loops forever
					if (!prox_rep)
						pst <= P_IDLE;
					else
						pst <= prox_wait0 ? P_OSC : P_WAIT;
				end
				P_OSC, P_CAL, P_LED_ON, P_LED_OFF, P_WAIT: begin
					if (p_end) begin
						p_cnt <= 16'h0000;
						unique case (pst)
							P_OSC:     pst <= P_CAL;
							P_CAL:     pst <= P_LED_ON;
							P_LED_ON:  pst <= P_LED_OFF;
							P_LED_OFF: pst <= P_CALC;
							default:   pst <= P_OSC;
						endcase
					end else if (tick) begin
						p_cnt <= p_cnt + 16'h0001;
					end
				end
			endcase
		end
	end

	// proximity samples and result
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lit <= 16'h0000;
			amb <= 16'h0000;
			prox_result <= 16'h0000;
		end else if (srst) begin
			lit <= 16'h0000;
			amb <= 16'h0000;
			prox_result <= 16'h0000;
		end else begin
			// (RULE_15) store lit and ambient samples
			if (pst == P_LED_ON && p_end)
				lit <= prox_sample;
			if (pst == P_LED_OFF && p_end)
				amb <= prox_sample;
			// (RULE_16) lit minus ambient, floored at zero
			if (pst == P_CALC)
				prox_result <= (lit > amb) ? lit - amb : 16'h0000;
		end
	end

	// light sequencer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lst <= L_IDLE;
			l_cnt <= 16'h0000;
			light_live <= 16'h0000;
		end else if (srst) begin
			lst <= L_IDLE;
			l_cnt <= 16'h0000;
			light_live <= 16'h0000;
		end else if (light_kick) begin
			lst <= light_any ? L_INTEG : L_IDLE;
			l_cnt <= 16'h0000;
		end else if (l_end) begin
			l_cnt <= 16'h0000;
			unique case (lst)
				L_INTEG: begin
					light_live <= light_sample;
					// (RULE_06) zero wait restarts at once
					// (RULE_08) sensor off right after each result
					if (!light_rep)
						lst <= L_IDLE;
					else
						lst <= light_wait0 ? L_INTEG : L_WAIT;
				end
				L_WAIT:  lst <= L_INTEG;
				default: lst <= L_IDLE;
			endcase
		end else if (tick && lst != L_IDLE) begin
			l_cnt <= l_cnt + 16'h0001;
		end
	end

	// bus view of the light result
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock <= 1'b0;
			light_shadow <= 16'h0000;
		end else begin
			// (RULE_09) frozen from read start until stop
			if (rd_begin_p)
				lock <= 1'b1;
			else if (stop_p)
				lock <= 1'b0;
			// the shadow catches up as soon as the lock drops
			if (srst)
				light_shadow <= 16'h0000;
			else if (!lock && !rd_begin_p)
				light_shadow <= light_live;
		end
	end

	// front-end controls, registered to keep them glitch free
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			osc_en <= 1'b0;
			prox_rx_power <= 1'b0;
			prox_rx_cal <= 1'b0;
			led_on <= 1'b0;
			light_power <= 1'b0;
		end else begin
			// (RULE_17) oscillator kept while light is measuring
			osc_en <= (pst != P_IDLE && pst != P_WAIT) || (lst == L_INTEG);
			prox_rx_power <= pst inside {P_CAL, P_LED_ON, P_LED_OFF};
			prox_rx_cal <= (pst == P_CAL);
			led_on <= (pst == P_LED_ON);
			// (RULE_08) off from the cycle after each result
			light_power <= (lst == L_INTEG) && !l_end;
		end
	end

	// hysteresis selection for the threshold logic
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			light_hyst_lower <= 1'b0;
			light_hyst_upper <= 1'b0;
		end else begin
			// (RULE_01) enable bit gates hysteresis
			// (RULE_02) side bit picks lower or upper limit
			light_hyst_lower <= cfg[lpm_pkg::A_LIGHT_CFG[5:0]][lpm_pkg::HYST_EN_BIT] &
				~cfg[lpm_pkg::A_LIGHT_CFG[5:0]][lpm_pkg::HYST_SIDE_BIT];
			light_hyst_upper <= cfg[lpm_pkg::A_LIGHT_CFG[5:0]][lpm_pkg::HYST_EN_BIT] &
				cfg[lpm_pkg::A_LIGHT_CFG[5:0]][lpm_pkg::HYST_SIDE_BIT];
		end
	end

	// (RULE_23) thresholds assembled high byte first
	assign prox_upper_threshold  = {cfg[lpm_pkg::A_PROX_UP_HIGH[5:0]],
		cfg[lpm_pkg::A_PROX_UP_LOW[5:0]]};
	assign light_lower_threshold = {cfg[lpm_pkg::A_LIGHT_LO_HIGH[5:0]],
		cfg[lpm_pkg::A_LIGHT_LO_LOW[5:0]]};
	assign led_setting = cfg[A_LED_SETTING[5:0]];
endmodule

// [sim/lpm_checker.sv]
// port assertions of the measurement controller
`timescale 1ns/1ps
module lpm_checker (
	input wire logic clk,              // clock
	input wire logic rstn,             // reset, active low
	input wire logic osc_en,           // oscillator
	input wire logic prox_rx_power,    // receiver power
	input wire logic prox_rx_cal,      // calibration
	input wire logic led_on,           // led pulse
	input wire logic light_power,      // light sensor on
	input wire logic light_hyst_lower, // lower side
	input wire logic light_hyst_upper  // upper side
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// calibration handing over to the lit sample
	sequence s_cal_end;
		prox_rx_cal ##1 (!prox_rx_cal && prox_rx_power);
	endsequence
	hyst_one_side_a: assert property (!(light_hyst_lower && light_hyst_upper))
		else $error("two hysteresis sides");
	cal_powered_a: assert property (prox_rx_cal |-> prox_rx_power && osc_en)
		else $error("calibration unpowered");
	led_powered_a: assert property (led_on |-> prox_rx_power && osc_en)
		else $error("led without receiver");
	cal_led_apart_a: assert property (!(prox_rx_cal && led_on))
		else $error("led during calibration");
	cal_then_led_a: assert property (s_cal_end |-> led_on)
		else $error("no led after calibration");
	osc_first_a: assert property ($rose(prox_rx_power) |-> $past(osc_en, 2))
		else $error("receiver before oscillator");
	dark_sample_a: assert property ($fell(led_on) && prox_rx_power |-> prox_rx_power[*4])
		else $error("ambient phase cut short");
	osc_stop_a: assert property ($fell(osc_en) |-> !prox_rx_power && !light_power)
		else $error("oscillator stopped while busy");
endmodule
bind lpm_measure_ctrl lpm_checker chk_i (.clk, .rstn, .osc_en, .prox_rx_power, .prox_rx_cal,
	.led_on, .light_power, .light_hyst_lower, .light_hyst_upper);

// [sim/lpm_host_model.sv]
// bus host model: clock, data and register transfers
`timescale 1ns/1ps
module lpm_host_model (
	input  wire logic clk,     // clock
	input  wire logic sda,     // resolved data line
	output logic      scl,     // bus clock
	output logic      sda_low  // host pulls data low
);
	int naks = 0; // missing acknowledges
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// one bit, 80 ns: low 5 cycles, high 3
	task automatic bitx(input logic b, output logic r);
		@(negedge clk) scl = 1'b0;
		@(negedge clk) sda_low = !b;
		repeat (4) @(negedge clk);
		scl = 1'b1;
		repeat (2) @(negedge clk);
		r = sda;
	endtask
	// start or repeated start
	task automatic start;
		@(negedge clk) scl = 1'b0;
		sda_low = 1'b0;
		repeat (4) @(negedge clk);
		scl = 1'b1;
		repeat (3) @(negedge clk);
		sda_low = 1'b1;
		repeat (3) @(negedge clk);
	endtask
	task automatic stop;
		@(negedge clk) scl = 1'b0;
		repeat (4) @(negedge clk) sda_low = 1'b1;
		repeat (3) @(negedge clk) scl = 1'b1;
		repeat (3) @(negedge clk) sda_low = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] r, input bit c = 1);
		logic k;
		for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
		bitx(a, k);
		// c low: the closing nack is our own
		if (a && k && c) naks++;
	endtask
	task automatic wr(input logic [7:0] p, d0, d1, input int n);
		logic [7:0] r;
		start;
		xb(8'h6e, 1'b1, r);
		xb(p, 1'b1, r);
		xb(d0, 1'b1, r);
		if (n > 1) xb(d1, 1'b1, r);
		stop;
	endtask
	task automatic rd(input logic [7:0] p, output logic [15:0] v);
		logic [7:0] r;
		start;
		xb(8'h6e, 1'b1, r);
		xb(p, 1'b1, r);
		start;
		xb(8'h6f, 1'b1, r);
		xb(8'hff, 1'b0, v[15:8]);
		xb(8'hff, 1'b1, v[7:0], 1'b0);
		stop;
	endtask
endmodule

// [sim/tb_light_proximity_measure_ctrl.sv]
// self-checking bench of the measurement controller
`timescale 1ns/1ps
module tb_light_proximity_measure_ctrl;
	localparam int T = 8; // shortened tick keeps the run brief
	logic clk, rstn, scl, sda_low, sda_out, sda_oe, osc_en, prox_rx_power, prox_rx_cal, led_on;
	logic light_power, light_hyst_lower, light_hyst_upper;
	logic [15:0] prox_sample, light_sample, prox_upper_threshold, light_lower_threshold;
	logic [15:0] prox_result, v, lit, amb;
	logic [7:0]  d, a;
	wire         sda = !(sda_oe || sda_low); // pulled up when released
	int          failures = 0, num_checks = 0, c, n;
	lpm_measure_ctrl #(.TICK_CYCLES(T)) DUT (.clk, .rstn, .scl_in(scl), .sda_in(sda),
		.sda_out, .sda_oe, .osc_en, .prox_rx_power, .prox_rx_cal, .led_on, .led_setting(),
		.prox_sample, .light_power, .light_sample, .light_hyst_lower, .light_hyst_upper,
		.prox_upper_threshold, .light_lower_threshold, .prox_result);
	lpm_host_model host (.clk, .sda, .scl, .sda_low);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// receiver shows the lit value only while the led pulses
	always @(negedge clk) prox_sample <= led_on ? lit : amb;
	task automatic chk(input string n, input logic [15:0] e, s);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// bounded wait for a power line to reach a level
	task automatic wt(input bit w, input logic l, output int n);
		n = 0;
		while ((w ? light_power : prox_rx_power) !== l) begin
			@(negedge clk);
			n++;
			if (n > 30000) begin
				failures++;
				test_done;
			end
		end
	endtask
	task automatic test_done;
		failures += host.naks;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		lit = 16'h0;
		amb = 16'h0;
		void'($urandom(72));
		light_sample = 16'($urandom);
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		host.rd(8'h25, v);
		chk("config defaults", 16'h040a, v);
		host.rd(8'h43, v);
		chk("light result", 16'h0, v);
		for (int i = 0; i < 4; i++) begin
			d = 8'(($urandom & 32'hc0) | (i << 4) | i);
			host.wr(8'h25, d, 8'h0, 1);
			chk("lower side", 16'(i == 2), 16'(light_hyst_lower));
			chk("upper side", 16'(i == 3), 16'(light_hyst_upper));
			host.rd(8'h25, v);
			chk("config back", {d & 8'h37, 8'h0a}, v);
		end
		d = 8'($urandom);
		a = 8'($urandom);
		host.wr(8'h22, d, a, 2);
		chk("light limit", {d, a}, light_lower_threshold);
		host.wr(8'h10, a, d, 2);
		chk("prox limit", {a, d}, prox_upper_threshold);
		lit = 16'h8000 | 16'($urandom);
		amb = 16'($urandom) & 16'h7fff;
		host.wr(8'h17, 8'h01, 8'h0, 1);
		wt(0, 1'b1, c);
		wt(0, 1'b0, n);
		chk("cycle short", 16'h1, 16'(c + n < 40 * T));
		repeat (4) @(negedge clk);
		chk("prox result", lit - amb, prox_result);
		host.rd(8'h41, v);
		chk("prox bytes", lit - amb, v);
		chk("osc off", 16'h0, 16'(osc_en));
		host.wr(8'h25, 8'h00, 8'h0, 1); // short time, test only
		host.wr(8'h26, 8'h00, 8'h02, 2);
		wt(1, 1'b1, c);
		wt(1, 1'b0, c);
		chk("integration", 16'h1, 16'(c >= 124 * T && c <= 126 * T));
		wt(1, 1'b1, c);
		chk("continuous", 16'h1, 16'(c < 2 * T));
		host.wr(8'h27, 8'h00, 8'h0, 1);
		wt(1, 1'b0, c);
		host.rd(8'h43, v);
		chk("light bytes", light_sample, v);
		host.wr(8'h01, 8'h01, 8'h0, 1);
		host.rd(8'h22, v);
		chk("soft reset", 16'h0, v | light_lower_threshold | prox_upper_threshold);
		test_done;
	end
endmodule
